//--- src/esg_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "esg_consts.svh"

module esg_top (
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire esg_pkg::esg_wb_req_s  wb_req,
    output logic                       wb_ack_o,
    output logic [31:0]                wb_dat_o,
    input  wire logic                  step_input_pin,
    input  wire logic                  direction_input_pin,
    output logic                       step_output_pin,
    output logic [`ESG_TABLE_W-1:0]    sine_table_pos
);
    import esg_pkg::*;

    logic [31:0]               cfg_r, cfg_nxt;
    logic signed [31:0]        gear_r, gear_nxt;
    logic signed [31:0]        start_velocity_r, start_velocity_nxt;
    logic [31:0]               start_acceleration_r, start_acceleration_nxt;
    logic signed [31:0]        apos_r, apos_nxt;
    logic signed [31:0]        tpos_r, tpos_nxt;
    logic signed [31:0]        rvel_r, rvel_nxt;
    logic signed [31:0]        racc_r, racc_nxt;
    logic [`ESG_FRAC_W-1:0]    frac_r, frac_nxt;
    logic [31:0]               phase_r, phase_nxt;
    logic                      last_dir_r, last_dir_nxt;
    esg_ctrl_e                 prev_ctrl_r, prev_ctrl_nxt;
    logic [9:0]                div_r, div_nxt;
    logic                      step_out_r, step_out_nxt;
    logic [`ESG_TABLE_W-1:0]   table_r, table_nxt;
    logic                      ack_r, ack_nxt;
    logic [31:0]               dat_r, dat_nxt;

    logic [1:0]                mode;
    esg_ctrl_e                 ctrl;
    logic                      step_event;
    logic                      pos_in;
    logic signed [32:0]        gear_ext, delta, sum;
    logic signed [8:0]         ovf;
    logic signed [31:0]        ovf_w;
    logic signed [31:0]        vel_learned;
    logic signed [31:0]        acc_start;
    logic [31:0]               vel_mag;
    logic [32:0]               psum;
    logic                      tick;
    logic [7:0]                idx;
    logic                      wr_go, handover_go;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m;
    endfunction

    esg_step_edge esg_step_edge_inst (
        .sys_clk        (sys_clk),
        .arst_n         (arst_n),
        .step_input_pin (step_input_pin),
        .mode           (mode),
        .step_event     (step_event)
    );
    assign mode = cfg_r[`ESG_CFG_MODE_MSB:`ESG_CFG_MODE_LSB];
    assign idx  = wb_req.adr[`ESG_ADR_W-1:2];
    // write lands on the edge where the master sees ack
    assign wr_go = wb_req.cyc & wb_req.stb & wb_req.we & ack_r;

    assign ctrl = (mode == `ESG_MODE_OFF) ? ESG_CTRL_INTERNAL :
                  cfg_r[`ESG_CFG_INDIRECT] ? ESG_CTRL_INDIRECT : ESG_CTRL_DIRECT;

    assign pos_in   = direction_input_pin ^ cfg_r[`ESG_CFG_POL_DIR];
    assign gear_ext = {gear_r[31], gear_r};
    assign delta    = pos_in ? gear_ext : -gear_ext;
    assign sum      = $signed({9'h000, frac_r}) + delta;
    assign ovf      = sum[32:`ESG_FRAC_W];
    assign ovf_w    = {{23{ovf[8]}}, ovf};

    assign vel_learned = last_dir_r ? start_velocity_r : -start_velocity_r;
    assign acc_start   = start_acceleration_r[`ESG_ACC_SIGN] ? -$signed({1'b0, start_acceleration_r[30:0]})
                                                 : $signed({1'b0, start_acceleration_r[30:0]});
    assign vel_mag     = rvel_r[31] ? 32'(-rvel_r) : 32'(rvel_r);
    assign psum        = {1'b0, phase_r} + {1'b0, vel_mag};
    assign tick        = (div_r == `ESG_ACC_DIV_MAX);
    assign handover_go = (ctrl == ESG_CTRL_INTERNAL) && (prev_ctrl_r == ESG_CTRL_DIRECT)
                         && cfg_r[`ESG_CFG_HANDOVER];

    always_comb begin
        cfg_nxt       = cfg_r;
        gear_nxt      = gear_r;
        start_velocity_nxt    = start_velocity_r;
        start_acceleration_nxt    = start_acceleration_r;
        apos_nxt      = apos_r;
        tpos_nxt      = tpos_r;
        rvel_nxt      = rvel_r;
        racc_nxt      = racc_r;
        frac_nxt      = frac_r;
        phase_nxt     = phase_r;
        last_dir_nxt  = last_dir_r;
        prev_ctrl_nxt = ctrl;
        div_nxt       = div_r + 10'h001;
        step_out_nxt  = 1'b0;

        if (step_event && ctrl != ESG_CTRL_INTERNAL) begin
            frac_nxt = sum[`ESG_FRAC_W-1:0];
            if (ovf != 9'sh000) begin
                last_dir_nxt = ~ovf[8];
            end
        end

        unique case (ctrl)
            ESG_CTRL_DIRECT: begin
                rvel_nxt = cfg_r[`ESG_CFG_HANDOVER] ? vel_learned : 32'sh0000_0000;
                racc_nxt = 32'sh0000_0000;
                if (step_event) begin
                    apos_nxt = apos_r + ovf_w;
                end
                // phase restarts at each external step that overflows into a whole position count
                if (step_event && ovf != 9'sh000) begin
                    phase_nxt = 32'h0000_0000;
                end else if (cfg_r[`ESG_CFG_HANDOVER]) begin
                    phase_nxt = psum[31:0];
                end
                // no internal steps while external drives
                step_out_nxt = 1'b0;
            end
            ESG_CTRL_INDIRECT: begin
                // overflows move target by their whole signed count
                if (step_event) begin
                    tpos_nxt = tpos_r + ovf_w;
                end
                rvel_nxt = (tpos_r > apos_r) ? start_velocity_r :
                           (tpos_r < apos_r) ? -start_velocity_r : 32'sh0000_0000;
                racc_nxt = 32'sh0000_0000;
                // only the ramp stepper moves position
                phase_nxt = psum[31:0];
                if (psum[32] && apos_r != tpos_r) begin
                    apos_nxt     = rvel_r[31] ? apos_r - 32'sh1 : apos_r + 32'sh1;
                    step_out_nxt = 1'b1;
                end
            end
            ESG_CTRL_INTERNAL: begin
                if (handover_go) begin
                    rvel_nxt = vel_learned;
                    racc_nxt = acc_start;
                end else if (tick) begin
                    rvel_nxt = rvel_r + racc_r;
                end
                phase_nxt = psum[31:0];
                if (psum[32]) begin
                    apos_nxt     = rvel_r[31] ? apos_r - 32'sh1 : apos_r + 32'sh1;
                    step_out_nxt = 1'b1;
                end
            end
        endcase

        // software writes win over internal updates
        if (wr_go) begin
            unique case (idx)
                `ESG_IDX_GENERAL_CONFIG:  cfg_nxt    = merge(cfg_r, wb_req.dat, wb_req.sel);
                `ESG_IDX_GEARING_FACTOR:  gear_nxt   = merge(gear_r, wb_req.dat, wb_req.sel);
                `ESG_IDX_START_VELOCITY:  start_velocity_nxt = merge(start_velocity_r, wb_req.dat, wb_req.sel);
                `ESG_IDX_START_ACCEL:     start_acceleration_nxt = merge(start_acceleration_r, wb_req.dat, wb_req.sel);
                `ESG_IDX_ACTUAL_POSITION: apos_nxt   = merge(apos_r, wb_req.dat, wb_req.sel);
                `ESG_IDX_TARGET_POSITION: tpos_nxt   = merge(tpos_r, wb_req.dat, wb_req.sel);
                default: ;
            endcase
        end
        table_nxt = apos_nxt[`ESG_TABLE_W-1:0];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r       <= `ESG_CFG_RESET;
            gear_r      <= `ESG_WORD_RESET;
            start_velocity_r    <= `ESG_WORD_RESET;
            start_acceleration_r    <= `ESG_WORD_RESET;
            apos_r      <= `ESG_WORD_RESET;
            tpos_r      <= `ESG_WORD_RESET;
            rvel_r      <= `ESG_WORD_RESET;
            racc_r      <= `ESG_WORD_RESET;
            frac_r      <= '0;
            phase_r     <= `ESG_WORD_RESET;
            last_dir_r  <= 1'b1;
            prev_ctrl_r <= ESG_CTRL_INTERNAL;
            div_r       <= '0;
            step_out_r  <= 1'b0;
            table_r     <= '0;
        end else begin
            cfg_r       <= cfg_nxt;
            gear_r      <= gear_nxt;
            start_velocity_r    <= start_velocity_nxt;
            start_acceleration_r    <= start_acceleration_nxt;
            apos_r      <= apos_nxt;
            tpos_r      <= tpos_nxt;
            rvel_r      <= rvel_nxt;
            racc_r      <= racc_nxt;
            frac_r      <= frac_nxt;
            phase_r     <= phase_nxt;
            last_dir_r  <= last_dir_nxt;
            prev_ctrl_r <= prev_ctrl_nxt;
            div_r       <= div_nxt;
            step_out_r  <= step_out_nxt;
            table_r     <= table_nxt;
        end
    end

    // single wait state; unmapped reads return zero
    always_comb begin
        ack_nxt = wb_req.cyc & wb_req.stb & ~ack_r;
        dat_nxt = dat_r;
        if (ack_nxt) begin
            unique case (idx)
                `ESG_IDX_GENERAL_CONFIG:  dat_nxt = cfg_r;
                `ESG_IDX_GEARING_FACTOR:  dat_nxt = gear_r;
                `ESG_IDX_START_VELOCITY:  dat_nxt = start_velocity_r;
                `ESG_IDX_START_ACCEL:     dat_nxt = start_acceleration_r;
                `ESG_IDX_ACTUAL_POSITION: dat_nxt = apos_r;
                `ESG_IDX_TARGET_POSITION: dat_nxt = tpos_r;
                `ESG_IDX_RAMP_VELOCITY:   dat_nxt = rvel_r;
                `ESG_IDX_RAMP_ACCEL:      dat_nxt = racc_r;
                `ESG_IDX_STATUS:          dat_nxt = {29'h0000_0000, last_dir_r, 2'(ctrl)};
                default:                  dat_nxt = `ESG_WORD_RESET;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            dat_r <= `ESG_WORD_RESET;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end
    assign wb_ack_o        = ack_r;
    assign wb_dat_o        = dat_r;
    assign step_output_pin = step_out_r;
    assign sine_table_pos  = table_r;
    wire logic wr_apos = wr_go && idx == `ESG_IDX_ACTUAL_POSITION;
    wire logic wr_tpos = wr_go && idx == `ESG_IDX_TARGET_POSITION;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_leave_direct;
        (ctrl == ESG_CTRL_DIRECT && cfg_r[`ESG_CFG_HANDOVER]) ##1
        (ctrl == ESG_CTRL_INTERNAL && cfg_r[`ESG_CFG_HANDOVER] && !wr_go);
    endsequence
    property p_hold_zero;
        (ctrl == ESG_CTRL_DIRECT && !cfg_r[`ESG_CFG_HANDOVER]) |=> rvel_r == 32'sh0;
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("ramp velocity not zero");
    property p_mirror;
        (ctrl == ESG_CTRL_DIRECT && cfg_r[`ESG_CFG_HANDOVER])
        |=> rvel_r == ($past(last_dir_r) ? $past(start_velocity_r) : -$past(start_velocity_r));
    endproperty
    a_mirror: assert property (p_mirror) else $error("velocity not mirrored");
    property p_indirect_pos;
        (ctrl == ESG_CTRL_INDIRECT && !wr_apos)
        |=> (apos_r - $past(apos_r)) inside {32'sh0, 32'sh1, -32'sh1};
    endproperty
    a_indirect_pos: assert property (p_indirect_pos) else $error("position jumped");
    property p_indirect_tgt;
        (ctrl == ESG_CTRL_INDIRECT && step_event && !wr_tpos)
        |=> tpos_r == $past(tpos_r) + $past(ovf_w);
    endproperty
    a_indirect_tgt: assert property (p_indirect_tgt) else $error("target not moved");
    property p_direct_jump;
        (ctrl == ESG_CTRL_DIRECT && step_event && !wr_apos)
        |=> apos_r == $past(apos_r) + $past(ovf_w) ##1 sine_table_pos == $past(apos_r[9:0]);
    endproperty
    a_direct_jump: assert property (p_direct_jump) else $error("position jump wrong");
    property p_dir;
        (ctrl == ESG_CTRL_DIRECT && step_event && ovf != 9'sh000 && !wr_apos)
        |=> (apos_r > $past(apos_r)) == $past(pos_in ^ gear_r[31]);
    endproperty
    a_dir: assert property (p_dir) else $error("wrong step direction");
    property p_rise;
        (mode == `ESG_MODE_RISE) && $rose(step_input_pin) |-> step_event;
    endproperty
    a_rise: assert property (p_rise) else $error("rising step missed");
    property p_handover_acc;
        s_leave_direct |=> racc_r == ($past(start_acceleration_r[31]) ? -$signed({1'b0, $past(start_acceleration_r[30:0])})
                                      : $signed({1'b0, $past(start_acceleration_r[30:0])}));
    endproperty
    a_handover_acc: assert property (p_handover_acc) else $error("start accel wrong");
    property p_handover_vel;
        s_leave_direct |=> rvel_r == ($past(last_dir_r) ? $past(start_velocity_r) : -$past(start_velocity_r));
    endproperty
    a_handover_vel: assert property (p_handover_vel) else $error("start velocity wrong");
    property p_phase;
        (ctrl == ESG_CTRL_DIRECT && step_event && ovf != 9'sh000) |=> phase_r == 32'h0;
    endproperty
    a_phase: assert property (p_phase) else $error("step timing not kept");
    property p_no_int_step;
        (ctrl == ESG_CTRL_DIRECT) [*2] |-> !step_output_pin;
    endproperty
    a_no_int_step: assert property (p_no_int_step) else $error("internal step in direct");
endmodule

`default_nettype wire

//--- src/esg_consts.svh
`ifndef ESG_CONSTS_SVH
`define ESG_CONSTS_SVH

// register indices; byte address is four times the index
`define ESG_IDX_GENERAL_CONFIG  8'h00
`define ESG_IDX_GEARING_FACTOR  8'h12
`define ESG_IDX_START_VELOCITY  8'h25
`define ESG_IDX_START_ACCEL     8'h2A
`define ESG_IDX_ACTUAL_POSITION 8'h40
`define ESG_IDX_TARGET_POSITION 8'h41
`define ESG_IDX_RAMP_VELOCITY   8'h42
`define ESG_IDX_RAMP_ACCEL      8'h43
`define ESG_IDX_STATUS          8'h44

// general_config fields
`define ESG_CFG_MODE_LSB        6
`define ESG_CFG_MODE_MSB        7
`define ESG_CFG_POL_DIR         8
`define ESG_CFG_INDIRECT        9
`define ESG_CFG_HANDOVER        26
`define ESG_CFG_RESET           32'h0000_0000

// step input modes
`define ESG_MODE_OFF            2'h0
`define ESG_MODE_RISE           2'h1
`define ESG_MODE_FALL           2'h2
`define ESG_MODE_BOTH           2'h3

// gearing: 8 integer bits, 24 fraction bits
`define ESG_FRAC_W              24
`define ESG_ACC_SIGN            31

// acceleration applied when the divider reaches this value, once per 1024 cycles
`define ESG_ACC_DIV_MAX         10'h3FF

`define ESG_WORD_RESET          32'h0000_0000
`define ESG_TABLE_W             10
`define ESG_ADR_W               10

`endif

//--- src/esg_pkg.sv
`include "esg_consts.svh"

package esg_pkg;

    typedef struct packed {
        logic                  cyc;
        logic                  stb;
        logic                  we;
        logic [`ESG_ADR_W-1:0] adr;
        logic [3:0]            sel;
        logic [31:0]           dat;
    } esg_wb_req_s;

    typedef enum logic [1:0] {
        ESG_CTRL_INTERNAL,
        ESG_CTRL_DIRECT,
        ESG_CTRL_INDIRECT
    } esg_ctrl_e;

endpackage

//--- src/esg_step_edge.sv
`timescale 1ns/100ps
`default_nettype none
`include "esg_consts.svh"

module esg_step_edge (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       step_input_pin,
    input  wire logic [1:0] mode,
    output logic            step_event
);
    logic prev_r;
    logic prev_nxt;

    always_comb begin
        prev_nxt = step_input_pin;
        unique case (mode)
            `ESG_MODE_RISE: step_event = step_input_pin & ~prev_r;
            `ESG_MODE_FALL: step_event = ~step_input_pin & prev_r;
            `ESG_MODE_BOTH: step_event = step_input_pin ^ prev_r;
            `ESG_MODE_OFF:  step_event = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
endmodule

`default_nettype wire

//--- tb/esg_step_src.sv
`timescale 1ns/100ps
`default_nettype none

module esg_step_src (
    input  wire logic sys_clk,
    output var logic  step_input_pin,
    output var logic  direction_input_pin
);
    initial begin
        step_input_pin = 1'b0;
        direction_input_pin = 1'b0;
    end

    // direction is set one clock before the step edge that send drives next
    task automatic set_dir(input logic d);
        @(posedge sys_clk);
        direction_input_pin <= d;
    endtask

    task automatic send(input int n, input int gap);
        repeat (n) begin
            @(posedge sys_clk);
            step_input_pin <= 1'b1;
            repeat (gap) @(posedge sys_clk);
            step_input_pin <= 1'b0;
            repeat (gap - 1) @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

`default_nettype wire

//--- tb/esg_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "esg_consts.svh"

module esg_top_tb;
    import esg_pkg::*;

    logic                    sys_clk;
    logic                    arst_n;
    esg_wb_req_s             wb_req;
    logic                    wb_ack_o;
    logic [31:0]             wb_dat_o;
    logic                    step_input_pin;
    logic                    direction_input_pin;
    logic                    step_output_pin;
    logic [`ESG_TABLE_W-1:0] sine_table_pos;
    int                      error_cnt = 0;
    int                      compares = 0;
    int                      pulses = 0;
    logic [31:0]             rd;

    esg_top esg_top_inst (
        .sys_clk             (sys_clk),
        .arst_n              (arst_n),
        .wb_req              (wb_req),
        .wb_ack_o            (wb_ack_o),
        .wb_dat_o            (wb_dat_o),
        .step_input_pin      (step_input_pin),
        .direction_input_pin (direction_input_pin),
        .step_output_pin     (step_output_pin),
        .sine_table_pos      (sine_table_pos)
    );

    esg_step_src esg_step_src_inst (
        .sys_clk             (sys_clk),
        .step_input_pin      (step_input_pin),
        .direction_input_pin (direction_input_pin)
    );

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (step_output_pin === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // classic cycle; ack and read data taken at the same edge
    task automatic xfer(input logic [7:0] idx, input logic we, input logic [31:0] wd);
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF, dat: wd};
        // no local limit: a lost ack is left to the watchdog
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(idx, 1'b1, d);
    endtask

    task automatic rdx(input logic [7:0] idx);
        xfer(idx, 1'b0, 32'h0000_0000);
    endtask

    task automatic t_regs();
        rdx(`ESG_IDX_GENERAL_CONFIG);
        chk(rd, `ESG_CFG_RESET, "config reset");
        rdx(`ESG_IDX_START_VELOCITY);
        chk(rd, 32'h0000_0000, "start velocity reset");
        wr(`ESG_IDX_START_ACCEL, 32'hA5A5_5A5A);
        rdx(`ESG_IDX_START_ACCEL);
        chk(rd, 32'hA5A5_5A5A, "start accel readback");
        wr(`ESG_IDX_RAMP_VELOCITY, 32'h1234_5678);
        rdx(`ESG_IDX_RAMP_VELOCITY);
        chk(rd, 32'h0000_0000, "read-only velocity");
        wr(8'h7F, 32'hFFFF_FFFF);
        rdx(8'h7F);
        chk(rd, 32'h0000_0000, "unmapped read");
    endtask

    task automatic t_modes();
        int mi;
        int p0;
        int ex [4] = '{0, 2, 2, 4};
        p0 = pulses;
        wr(`ESG_IDX_GEARING_FACTOR, 32'h0100_0000);
        esg_step_src_inst.set_dir(1'b1);
        for (mi = 0; mi < 4; mi++) begin
            wr(`ESG_IDX_ACTUAL_POSITION, 32'h0000_0000);
            wr(`ESG_IDX_GENERAL_CONFIG, 32'(mi) << `ESG_CFG_MODE_LSB);
            esg_step_src_inst.send(2, 8);
            rdx(`ESG_IDX_ACTUAL_POSITION);
            chk(rd, 32'(ex[mi]), "steps per mode");
        end
        chk(32'(pulses - p0), 32'h0000_0000, "internal steps in direct mode");
    endtask

    task automatic t_gear();
        int          i;
        logic [31:0] gt [5] = '{32'h0080_0000, 32'h0300_0000, 32'hFD00_0000,
                                32'h0300_0000, 32'h0300_0000};
        logic        pl [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic        dr [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        int          ex [5] = '{2, 3, -3, -3, 3};
        for (i = 0; i < 5; i++) begin
            wr(`ESG_IDX_ACTUAL_POSITION, 32'h0000_0000);
            wr(`ESG_IDX_GEARING_FACTOR, gt[i]);
            wr(`ESG_IDX_GENERAL_CONFIG, 32'h0000_0040 | (32'(pl[i]) << `ESG_CFG_POL_DIR));
            esg_step_src_inst.set_dir(dr[i]);
            esg_step_src_inst.send(i == 0 ? 4 : 1, 8);
            rdx(`ESG_IDX_ACTUAL_POSITION);
            chk(rd, 32'(ex[i]), "geared position");
            chk(32'(sine_table_pos), rd & 32'h0000_03FF, "table jump");
        end
        rdx(`ESG_IDX_RAMP_VELOCITY);
        chk(rd, 32'h0000_0000, "velocity held in direct mode");
    endtask

    task automatic t_indirect();
        wr(`ESG_IDX_GEARING_FACTOR, 32'h0100_0000);
        wr(`ESG_IDX_START_VELOCITY, 32'h0000_0000);
        wr(`ESG_IDX_ACTUAL_POSITION, 32'h0000_0010);
        wr(`ESG_IDX_TARGET_POSITION, 32'h0000_0010);
        wr(`ESG_IDX_GENERAL_CONFIG, 32'h0000_0240);
        rdx(`ESG_IDX_STATUS);
        chk(rd & 32'h0000_0003, 32'h0000_0002, "indirect selected");
        esg_step_src_inst.set_dir(1'b1);
        esg_step_src_inst.send(3, 64);
        esg_step_src_inst.set_dir(1'b0);
        esg_step_src_inst.send(1, 64);
        rdx(`ESG_IDX_TARGET_POSITION);
        chk(rd, 32'h0000_0012, "target moved");
        rdx(`ESG_IDX_ACTUAL_POSITION);
        chk(rd, 32'h0000_0010, "position untouched");
    endtask

    task automatic t_handover();
        int          p0;
        logic [31:0] a0;
        wr(`ESG_IDX_START_VELOCITY, 32'h1000_0000);
        wr(`ESG_IDX_START_ACCEL, 32'h8000_0005);
        wr(`ESG_IDX_GENERAL_CONFIG, 32'h0400_0040);
        p0 = pulses;
        esg_step_src_inst.set_dir(1'b0);
        esg_step_src_inst.send(2, 16);
        rdx(`ESG_IDX_STATUS);
        chk(rd & 32'h0000_0004, 32'h0000_0000, "learned direction");
        rdx(`ESG_IDX_RAMP_VELOCITY);
        chk(rd, 32'hF000_0000, "reported velocity");
        chk(32'(pulses - p0), 32'h0000_0000, "no internal steps");
        rdx(`ESG_IDX_ACTUAL_POSITION);
        a0 = rd;
        p0 = pulses;
        wr(`ESG_IDX_GENERAL_CONFIG, 32'h0400_0000);
        repeat (160) @(posedge sys_clk);
        rdx(`ESG_IDX_ACTUAL_POSITION);
        a0 = a0 - rd;
        // one step per 16 cycles, bus latency blurs the edges
        chk(32'($signed(a0) >= 9 && $signed(a0) <= 11), 32'h0000_0001, "ramp moved");
        chk(32'(pulses - p0 >= 9 && pulses - p0 <= 11), 32'h0000_0001, "step pulses");
        rdx(`ESG_IDX_RAMP_ACCEL);
        chk(rd, 32'hFFFF_FFFB, "start accel sign");
        rdx(`ESG_IDX_RAMP_VELOCITY);
        chk(32'(rd === 32'hF000_0000 || rd === 32'hEFFF_FFFB), 32'h0000_0001, "ramp vel");
        wr(`ESG_IDX_START_ACCEL, 32'h0000_0000);
        wr(`ESG_IDX_START_VELOCITY, 32'h0800_0000);
        wr(`ESG_IDX_GENERAL_CONFIG, 32'h0400_0040);
        esg_step_src_inst.set_dir(1'b1);
        esg_step_src_inst.send(1, 16);
        rdx(`ESG_IDX_STATUS);
        chk(rd & 32'h0000_0004, 32'h0000_0004, "learned positive");
        wr(`ESG_IDX_GENERAL_CONFIG, 32'h0400_0000);
        rdx(`ESG_IDX_RAMP_ACCEL);
        chk(rd, 32'h0000_0000, "zero start accel");
        rdx(`ESG_IDX_RAMP_VELOCITY);
        chk(rd, 32'h0800_0000, "positive start velocity");
    endtask

    task automatic test_done();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        wb_req = '0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        t_modes();
        t_gear();
        t_indirect();
        t_handover();
        test_done();
    end

    // whole run is under two thousand cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        test_done();
    end
endmodule

`default_nettype wire
